// ---- inc/atrb_params.svh ----
`ifndef ATRB_PARAMS_SVH
`define ATRB_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////
// register indices; the byte address is four times the index
`define ATRB_IDX_OFFSET_ADC2_B  10'h336
`define ATRB_IDX_OFFSET_ADC3_C  10'h338
`define ATRB_IDX_OFFSET_ADC3_D  10'h33A
`define ATRB_IDX_OFFSET_CORE4   10'h33C
`define ATRB_IDX_OFFSET_CORE5   10'h33E
`define ATRB_IDX_GAIN_CORE0     10'h360
`define ATRB_IDX_GAIN_CORE1     10'h361

////////////////////////////////////////////////////////////////////////////
// storage slots, also the fuse word order
`define ATRB_SLOT_OFFSET_ADC2_B 3'h0
`define ATRB_SLOT_OFFSET_ADC3_C 3'h1
`define ATRB_SLOT_OFFSET_ADC3_D 3'h2
`define ATRB_SLOT_OFFSET_CORE4  3'h3
`define ATRB_SLOT_OFFSET_CORE5  3'h4
`define ATRB_SLOT_GAIN_CORE0    3'h5
`define ATRB_SLOT_GAIN_CORE1    3'h6
`define ATRB_NUM_SLOTS          7
`define ATRB_LAST_SLOT          3'h6
`define ATRB_FIRST_GAIN_SLOT    3'h5

////////////////////////////////////////////////////////////////////////////
// fields, reset values, responses
`define ATRB_OFFSET_MSB         11
`define ATRB_GAIN_MSB           4
`define ATRB_RESET_TRIM         16'h0000
`define ATRB_GAIN_REG_MASK      16'h00FF
`define ATRB_OFFSET_REG_MASK    16'hFFFF
`define ATRB_RESP_OKAY          2'h0
`define ATRB_RESP_SLVERR        2'h2
`define ATRB_RESP_DECERR        2'h3

`endif

// ---- inc/atrb_pkg.sv ----
package atrb_pkg;

  typedef logic [15:0] atrb_word_t;
  typedef logic [12:0] atrb_corr_t;

  typedef enum logic [2:0] {
    ATRB_LD_REQ  = 3'b001,
    ATRB_LD_WAIT = 3'b010,
    ATRB_LD_DONE = 3'b100
  } atrb_load_state_t;

endpackage

// ---- design/atrb_fuse_load.sv ----
`timescale 1ns/1ps
`include "atrb_params.svh"

module atrb_fuse_load
  import atrb_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  output logic            fuse_req,
  output logic [2:0]      fuse_addr,
  input  wire atrb_word_t fuse_data,
  input  wire logic       fuse_ack,
  output logic            load_valid,
  output logic [2:0]      load_slot,
  output atrb_word_t      load_data,
  output logic            load_done
);

  atrb_load_state_t state_q, state_d;
  logic             req_q, req_d;
  logic [2:0]       addr_q, addr_d;
  logic             valid_q, valid_d;
  logic [2:0]       slot_q, slot_d;
  atrb_word_t       data_q, data_d;
  logic             done_q, done_d;

  ////////////////////////////////////////////////////////////////////////
  // walk all slots once after reset, one fuse word per handshake
  always_comb begin
    state_d = state_q;
    req_d   = req_q;
    addr_d  = addr_q;
    valid_d = 1'b0;
    slot_d  = slot_q;
    data_d  = data_q;
    done_d  = done_q;
    case (state_q)
      ATRB_LD_REQ: begin
        req_d   = 1'b1;
        state_d = ATRB_LD_WAIT;
      end
      ATRB_LD_WAIT: begin
        if (fuse_ack) begin
          req_d   = 1'b0;
          valid_d = 1'b1;
          slot_d  = addr_q;
          data_d  = fuse_data;
          if (addr_q == `ATRB_LAST_SLOT) begin
            state_d = ATRB_LD_DONE;
            done_d  = 1'b1;
          end else begin
            addr_d  = addr_q + 3'h1;
            state_d = ATRB_LD_REQ;
          end
        end
      end
      ATRB_LD_DONE: begin
        state_d = ATRB_LD_DONE;
      end
      default: begin
        state_d = ATRB_LD_REQ;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ATRB_LD_REQ;
      req_q   <= 1'b0;
      addr_q  <= 3'h0;
      valid_q <= 1'b0;
      slot_q  <= 3'h0;
      data_q  <= `ATRB_RESET_TRIM;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      req_q   <= req_d;
      addr_q  <= addr_d;
      valid_q <= valid_d;
      slot_q  <= slot_d;
      data_q  <= data_d;
      done_q  <= done_d;
    end
  end

  assign fuse_req   = req_q;
  assign fuse_addr  = addr_q;
  assign load_valid = valid_q;
  assign load_slot  = slot_q;
  assign load_data  = data_q;
  assign load_done  = done_q;

endmodule // atrb_fuse_load

// ---- design/atrb_top.sv ----
// What this block does
// - adc2 input b adds its own offset
// - adc3 picks offset by input c or d
// - adc4 and adc5 each use own offset
// - trim defaults load from fuses at startup
// - 5-bit fine gain for cores zero, one
// - offset trims are unsigned numbers
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "atrb_params.svh"

module atrb_top
  import atrb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        cal_offset_busy,
  output logic             fuse_req,
  output logic [2:0]       fuse_addr,
  input  wire atrb_word_t  fuse_data,
  input  wire logic        fuse_ack,
  input  wire logic [11:0] adc2_sample,
  input  wire logic        analog_input_b,
  input  wire logic [11:0] adc3_sample,
  input  wire logic        analog_input_d,
  input  wire logic [11:0] adc4_sample,
  input  wire logic [11:0] adc5_sample,
  output atrb_corr_t       adc2_corr,
  output atrb_corr_t       adc3_corr,
  output atrb_corr_t       adc4_corr,
  output atrb_corr_t       adc5_corr,
  output logic [4:0]       gain_core0,
  output logic [4:0]       gain_core1,
  output logic             trims_loaded
);

  ////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [3:0] atrb_decode(input logic [11:0] addr);
    logic [3:0] r;
    r = 4'h0;
    if (addr[1:0] == 2'h0) begin
      case (addr[11:2])
        `ATRB_IDX_OFFSET_ADC2_B: r = {1'b1, `ATRB_SLOT_OFFSET_ADC2_B};
        `ATRB_IDX_OFFSET_ADC3_C: r = {1'b1, `ATRB_SLOT_OFFSET_ADC3_C};
        `ATRB_IDX_OFFSET_ADC3_D: r = {1'b1, `ATRB_SLOT_OFFSET_ADC3_D};
        `ATRB_IDX_OFFSET_CORE4:  r = {1'b1, `ATRB_SLOT_OFFSET_CORE4};
        `ATRB_IDX_OFFSET_CORE5:  r = {1'b1, `ATRB_SLOT_OFFSET_CORE5};
        `ATRB_IDX_GAIN_CORE0:    r = {1'b1, `ATRB_SLOT_GAIN_CORE0};
        `ATRB_IDX_GAIN_CORE1:    r = {1'b1, `ATRB_SLOT_GAIN_CORE1};
        default:                 r = 4'h0;
      endcase
    end
    return r;
  endfunction

  function automatic atrb_word_t atrb_mask(input logic [2:0] slot);
    return (slot >= `ATRB_FIRST_GAIN_SLOT) ? `ATRB_GAIN_REG_MASK
                                          : `ATRB_OFFSET_REG_MASK;
  endfunction

  // offset is zero-extended, never sign-extended
  function automatic atrb_corr_t atrb_add(input logic [11:0] s,
                                          input logic [11:0] o);
    return {1'b0, s} + {1'b0, o};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // fuse default loader
  logic       load_valid;
  logic [2:0] load_slot;
  atrb_word_t load_data;
  logic       load_done;

  atrb_fuse_load u_fuse_load (
    .clk        (clk),
    .rst        (rst),
    .fuse_req   (fuse_req),
    .fuse_addr  (fuse_addr),
    .fuse_data  (fuse_data),
    .fuse_ack   (fuse_ack),
    .load_valid (load_valid),
    .load_slot  (load_slot),
    .load_data  (load_data),
    .load_done  (load_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // register file and axi4-lite slave
  atrb_word_t  regs_q [`ATRB_NUM_SLOTS];
  atrb_word_t  regs_d [`ATRB_NUM_SLOTS];
  logic        awready_q, awready_d, wready_q, wready_d;
  logic        aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [11:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0]  wstrb_q, wstrb_d;
  logic        bvalid_q, bvalid_d;
  logic [1:0]  bresp_q, bresp_d;
  logic        arready_q, arready_d, rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0]  rresp_q, rresp_d;
  logic [3:0]  wdec, rdec;
  logic        do_write;
  atrb_word_t  wmask, wnew;

  always_comb begin
    regs_d    = regs_q;
    aw_hold_d = aw_hold_q;
    w_hold_d  = w_hold_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    wdec      = atrb_decode(awaddr_q);
    rdec      = atrb_decode(s_axi_araddr);
    wmask     = atrb_mask(wdec[2:0]);
    wnew      = regs_q[wdec[2:0]];
    do_write  = aw_hold_q & w_hold_q & ~bvalid_q;
    if (s_axi_awvalid & awready_q) begin
      aw_hold_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid & wready_q) begin
      w_hold_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
    end
    // reserved bits are stored as written, except gain bits 15:8, which are masked to zero; software keeps them zero
    wnew[7:0]  = wstrb_q[0] ? wdata_q[7:0] : wnew[7:0];
    wnew[15:8] = wstrb_q[1] ? wdata_q[15:8] : wnew[15:8];
    if (do_write) begin
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bvalid_d  = 1'b1;
      if (!wdec[3]) begin
        bresp_d = `ATRB_RESP_DECERR;
      end else if (cal_offset_busy && wdec[2:0] < `ATRB_FIRST_GAIN_SLOT) begin
        bresp_d = `ATRB_RESP_SLVERR;
      end else begin
        bresp_d = `ATRB_RESP_OKAY;
        regs_d[wdec[2:0]] = wnew & wmask;
      end
    end else if (bvalid_q & s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid & arready_q) begin
      rvalid_d = 1'b1;
      rdata_d  = 32'h0000_0000;
      if (!rdec[3]) begin
        rresp_d = `ATRB_RESP_DECERR;
      end else if (cal_offset_busy && rdec[2:0] < `ATRB_FIRST_GAIN_SLOT) begin
        rresp_d = `ATRB_RESP_SLVERR;
      end else begin
        rresp_d = `ATRB_RESP_OKAY;
        rdata_d = {16'h0000, regs_q[rdec[2:0]]};
      end
    end else if (rvalid_q & s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    // fuse words land before the bus opens, so no collision with writes
    if (load_valid) begin
      regs_d[load_slot] = load_data & atrb_mask(load_slot);
    end
    awready_d = load_done & ~aw_hold_d & ~bvalid_d;
    wready_d  = load_done & ~w_hold_d & ~bvalid_d;
    arready_d = load_done & ~rvalid_d;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regs_q    <= '{default: `ATRB_RESET_TRIM};
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= 12'h000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `ATRB_RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `ATRB_RESP_OKAY;
    end else begin
      regs_q    <= regs_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      aw_hold_q <= aw_hold_d;
      w_hold_q  <= w_hold_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // trim datapath, one register stage
  atrb_corr_t a2_q, a2_d, a3_q, a3_d, a4_q, a4_d, a5_q, a5_d;
  logic [4:0] g0_q, g0_d, g1_q, g1_d;
  logic       loaded_q, loaded_d;

  always_comb begin
    // input a has its trim elsewhere, so it passes through here
    a2_d = analog_input_b ? atrb_add(adc2_sample,
      regs_q[`ATRB_SLOT_OFFSET_ADC2_B][`ATRB_OFFSET_MSB:0])
      : {1'b0, adc2_sample};
    a3_d = atrb_add(adc3_sample, analog_input_d
      ? regs_q[`ATRB_SLOT_OFFSET_ADC3_D][`ATRB_OFFSET_MSB:0]
      : regs_q[`ATRB_SLOT_OFFSET_ADC3_C][`ATRB_OFFSET_MSB:0]);
    a4_d = atrb_add(adc4_sample,
      regs_q[`ATRB_SLOT_OFFSET_CORE4][`ATRB_OFFSET_MSB:0]);
    a5_d = atrb_add(adc5_sample,
      regs_q[`ATRB_SLOT_OFFSET_CORE5][`ATRB_OFFSET_MSB:0]);
    g0_d = regs_q[`ATRB_SLOT_GAIN_CORE0][`ATRB_GAIN_MSB:0];
    g1_d = regs_q[`ATRB_SLOT_GAIN_CORE1][`ATRB_GAIN_MSB:0];
    loaded_d = load_done;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      a2_q     <= 13'h0000;
      a3_q     <= 13'h0000;
      a4_q     <= 13'h0000;
      a5_q     <= 13'h0000;
      g0_q     <= 5'h00;
      g1_q     <= 5'h00;
      loaded_q <= 1'b0;
    end else begin
      a2_q     <= a2_d;
      a3_q     <= a3_d;
      a4_q     <= a4_d;
      a5_q     <= a5_d;
      g0_q     <= g0_d;
      g1_q     <= g1_d;
      loaded_q <= loaded_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign adc2_corr     = a2_q;
  assign adc3_corr     = a3_q;
  assign adc4_corr     = a4_q;
  assign adc5_corr     = a5_q;
  assign gain_core0    = g0_q;
  assign gain_core1    = g1_q;
  assign trims_loaded  = loaded_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  // the edge that releases reset still loads reset values, so skip it
  property p_adc2_b;
    @(posedge clk) disable iff (rst)
    !rst && analog_input_b |=> adc2_corr == {1'b0, $past(adc2_sample)}
      + {1'b0, $past(regs_q[0][11:0])};
  endproperty
  a_adc2_b: assert property (p_adc2_b)
    else $error("adc2 input b offset not applied");
  property p_adc3_sel;
    @(posedge clk) disable iff (rst)
    !rst |=> adc3_corr == ($past(analog_input_d)
      ? {1'b0, $past(adc3_sample)} + {1'b0, $past(regs_q[2][11:0])}
      : {1'b0, $past(adc3_sample)} + {1'b0, $past(regs_q[1][11:0])});
  endproperty
  a_adc3_sel: assert property (p_adc3_sel)
    else $error("adc3 offset chosen for wrong input");
  property p_core45;
    @(posedge clk) disable iff (rst)
    !rst |=> (adc4_corr - {1'b0, $past(adc4_sample)} ==
         {1'b0, $past(regs_q[3][11:0])}) &&
        (adc5_corr - {1'b0, $past(adc5_sample)} ==
         {1'b0, $past(regs_q[4][11:0])});
  endproperty
  a_core45: assert property (p_core45)
    else $error("core4 or core5 offset wrong");
  property p_fuse_load;
    @(posedge clk) disable iff (rst)
    load_valid |=> regs_q[$past(load_slot)] ==
      ($past(load_data) & atrb_mask($past(load_slot)));
  endproperty
  a_fuse_load: assert property (p_fuse_load)
    else $error("fuse default not stored");
  property p_gain_write;
    @(posedge clk) disable iff (rst)
    (do_write && wdec == {1'b1, `ATRB_SLOT_GAIN_CORE0} && wstrb_q[0] &&
     !cal_offset_busy) |-> ##2 gain_core0 == $past(wdata_q[4:0], 2);
  endproperty
  a_gain_write: assert property (p_gain_write)
    else $error("gain core0 not updated by write");
  property p_gain_hi_zero;
    @(posedge clk) disable iff (rst)
    regs_q[5][15:8] == 8'h00 && regs_q[6][15:8] == 8'h00;
  endproperty
  a_gain_hi_zero: assert property (p_gain_hi_zero)
    else $error("gain register wider than eight bits");
  property p_unsigned;
    @(posedge clk) disable iff (rst)
    !rst |=> adc4_corr >= {1'b0, $past(adc4_sample)} &&
        adc5_corr >= {1'b0, $past(adc5_sample)};
  endproperty
  a_unsigned: assert property (p_unsigned)
    else $error("offset treated as signed");
endmodule // atrb_top

// ---- verification/atrb_tb_top.sv ----
`timescale 1ns/1ps
`include "atrb_params.svh"

module atrb_tb_top
  import atrb_pkg::*;
;
  logic        clk;
  logic        rst;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, cal_offset_busy;
  logic        fuse_req, analog_input_b, analog_input_d;
  logic        fuse_ack = 1'b0;
  logic [2:0]  fuse_addr;
  atrb_word_t  fuse_data = 16'h0000;
  logic [11:0] adc2_sample, adc3_sample, adc4_sample, adc5_sample;
  atrb_corr_t  adc2_corr, adc3_corr, adc4_corr, adc5_corr;
  logic [4:0]  gain_core0, gain_core1;
  logic        trims_loaded;
  int          num_errors;
  int          cmp_count;
  logic [9:0]  idx [7] = '{`ATRB_IDX_OFFSET_ADC2_B, `ATRB_IDX_OFFSET_ADC3_C,
    `ATRB_IDX_OFFSET_ADC3_D, `ATRB_IDX_OFFSET_CORE4, `ATRB_IDX_OFFSET_CORE5,
    `ATRB_IDX_GAIN_CORE0, `ATRB_IDX_GAIN_CORE1};
  // gain fuse words carry junk above bit 7 to prove the mask
  atrb_word_t  fuse_val [7] = '{16'h0123, 16'h0456, 16'h0789, 16'h0ABC,
    16'h0DEF, 16'h3315, 16'hC40A};
  atrb_word_t  wr_val [7] = '{16'h0FFF, 16'h0001, 16'h0800, 16'h07FF,
    16'h0FFE, 16'h001F, 16'h0011};
  logic [1:0]  r;
  logic [31:0] d;

  atrb_top dut (
    .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cal_offset_busy, .fuse_req, .fuse_addr,
    .fuse_data, .fuse_ack, .adc2_sample, .analog_input_b, .adc3_sample,
    .analog_input_d, .adc4_sample, .adc5_sample, .adc2_corr, .adc3_corr,
    .adc4_corr, .adc5_corr, .gain_core0, .gain_core1, .trims_loaded
  );

  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // fuse store: one ack per request, data line toggles when not valid
  always @(posedge clk) begin
    if (fuse_req === 1'b1 && fuse_ack === 1'b0) begin
      fuse_ack  <= 1'b1;
      fuse_data <= fuse_val[fuse_addr];
    end else begin
      fuse_ack  <= 1'b0;
      fuse_data <= ~fuse_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  function automatic logic [11:0] ra(input int i);
    return {idx[i], 2'b00};
  endfunction

  // bready stays high throughout, so a response is taken when first seen
  task automatic axi_write(input logic [11:0] a, input logic [31:0] v,
                           input logic [3:0] s, output logic [1:0] rr);
    bit aw;
    bit w;
    bit b;
    aw = 0;
    w = 0;
    b = 0;
    rr = 2'h1;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (int n = 0; n < 200 && !b; n++) begin
      @(posedge clk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid === 1'b1) begin
        b = 1;
        rr = s_axi_bresp;
      end
    end
    chk("bvalid", b, 1'b1);
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] v,
                          output logic [1:0] rr);
    bit ar;
    bit got;
    ar = 0;
    got = 0;
    rr = 2'h1;
    v = 32'hFFFF_FFFF;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (int n = 0; n < 200 && !got; n++) begin
      @(posedge clk);
      if (!ar && s_axi_arready === 1'b1) begin
        ar = 1;
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid === 1'b1) begin
        got = 1;
        v = s_axi_rdata;
        rr = s_axi_rresp;
      end
    end
    chk("rvalid", got, 1'b1);
  endtask

  task automatic do_reset();
    bit ok;
    ok = 0;
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    chk("rst fuse_req", fuse_req, 1'b0);
    chk("rst awready", s_axi_awready, 1'b0);
    chk("rst loaded", trims_loaded, 1'b0);
    rst <= 1'b0;
    for (int n = 0; n < 300 && !ok; n++) begin
      @(posedge clk);
      ok = (trims_loaded === 1'b1);
    end
    chk("trims_loaded", ok, 1'b1);
  endtask

  task automatic chk_regs(input atrb_word_t v [7]);
    atrb_word_t m;
    for (int i = 0; i < 7; i++) begin
      m = (i >= 5) ? `ATRB_GAIN_REG_MASK : `ATRB_OFFSET_REG_MASK;
      axi_read(ra(i), d, r);
      chk("reg rresp", r, `ATRB_RESP_OKAY);
      chk("reg rdata", d, {16'h0000, v[i] & m});
    end
    chk("gain_core0", gain_core0, v[5][4:0]);
    chk("gain_core1", gain_core1, v[6][4:0]);
  endtask

  // unsigned 13-bit sum: offset 0xFFF on sample 0xFFF must give 0x1FFE
  function automatic atrb_corr_t sum(input logic [11:0] s,
                                     input atrb_word_t o);
    return {1'b0, s} + {1'b0, o[`ATRB_OFFSET_MSB:0]};
  endfunction

  task automatic chk_corr(input atrb_word_t v [7]);
    logic [11:0] s;
    for (int k = 0; k < 2; k++) begin
      s = (k == 0) ? 12'hFFF : 12'h5A5;
      analog_input_b <= (k == 0);
      analog_input_d <= (k == 1);
      adc2_sample <= s;
      adc3_sample <= s;
      adc4_sample <= s;
      adc5_sample <= s;
      repeat (2) @(posedge clk);
      chk("adc2_corr", adc2_corr,
          (k == 0) ? sum(s, v[0]) : {1'b0, s});
      chk("adc3_corr", adc3_corr, sum(s, v[k + 1]));
      chk("adc4_corr", adc4_corr, sum(s, v[3]));
      chk("adc5_corr", adc5_corr, sum(s, v[4]));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    num_errors = 0;
    cmp_count = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    {cal_offset_busy, analog_input_b, analog_input_d} = '0;
    {adc2_sample, adc3_sample, adc4_sample, adc5_sample} = '0;
    do_reset();
    chk_regs(fuse_val);
    chk_corr(fuse_val);
    // reserved bits written as zero in every value
    for (int i = 0; i < 7; i++) begin
      axi_write(ra(i), {16'h0000, wr_val[i]}, 4'hF, r);
      chk("wr bresp", r, `ATRB_RESP_OKAY);
    end
    repeat (2) @(posedge clk);
    chk_regs(wr_val);
    chk_corr(wr_val);
    // offsets are refused while calibration runs, gains are not
    cal_offset_busy <= 1'b1;
    axi_write(ra(0), 32'h0000_0555, 4'hF, r);
    chk("busy bresp", r, `ATRB_RESP_SLVERR);
    axi_read(ra(1), d, r);
    chk("busy rresp", r, `ATRB_RESP_SLVERR);
    chk("busy rdata", d, 32'h0000_0000);
    axi_write(ra(5), 32'h0000_0003, 4'hF, r);
    chk("gain bresp", r, `ATRB_RESP_OKAY);
    cal_offset_busy <= 1'b0;
    wr_val[5] = 16'h0003;
    // low byte lane only: high byte keeps its value
    axi_write(ra(3), 32'h0000_0A55, 4'h1, r);
    chk("strb bresp", r, `ATRB_RESP_OKAY);
    wr_val[3] = 16'h0755;
    repeat (2) @(posedge clk);
    chk_regs(wr_val);
    chk_corr(wr_val);
    // unmapped, misaligned and out-of-block addresses
    axi_write(12'h004, 32'h0000_0001, 4'hF, r);
    chk("unmapped bresp", r, `ATRB_RESP_DECERR);
    foreach (idx[i]) begin
      if (i < 3) begin
        axi_read((i == 0) ? 12'h004 : (i == 1) ? 12'hCDA : 12'hD88, d, r);
        chk("unmapped rresp", r, `ATRB_RESP_DECERR);
        chk("unmapped rdata", d, 32'h0000_0000);
      end
    end
    // second reset in mid-run reloads the fuse defaults
    do_reset();
    chk_regs(fuse_val);
    test_done();
  end

  initial begin
    #200000;
    num_errors++;
    test_done();
  end

endmodule // atrb_tb_top
